// [pkg/prdp_pkg.sv]
// Summary of operation
// - At most one BAR-decode bit of descriptor bits 135:128 is ever set.
// - Data framing rises together with the request when the packet has payload.
// - Data framing drops at least one cycle before the final payload beat is shown.
// - Word-valid strobe is high only while the payload bus holds valid data.
// - Payload bus is two DWORDs wide, placed by a low descriptor address bit.
// - 64-bit addressing: descriptor bit 2 selects the half for the first DWORD.
// - 32-bit addressing: descriptor bit 34 selects the half for the first DWORD.
// - Later DWORDs fill remaining halves in order, little-endian quadword aligned.
// - An eight-bit byte-qualifier vector marks each valid payload byte.
// - The eight-lane variant provides no byte qualifiers.
// - Each virtual channel, 0 or 1, has its own independent instance.
// - Descriptor bit 126 set means a data phase follows.
`default_nettype none
package prdp_pkg;
	localparam int DESC_W       = 136;
	localparam int BAR_LSB      = 128;
	localparam int BAR_W        = 8;
	localparam int HAS_DATA_BIT = 126;
	localparam int ADDR64_BIT   = 125;
	localparam int OFS64_BIT    = 2;
	localparam int OFS32_BIT    = 34;
	localparam int DATA_W       = 64;
	localparam int DW_W         = 32;
	localparam int QUAL_W       = 8;
	localparam int LEN_W        = 10;
	localparam int FIFO_DEPTH   = 16;
	localparam logic [3:0] DW_QUAL = 4'hf;

	typedef enum logic [1:0] {IDLE, REQ, DATA} prdp_state_type;

	// Descriptor as handed over by the receive buffer, with payload length
	typedef struct packed {
		logic [DESC_W-1:0] desc;
		logic [LEN_W-1:0]  lenDw;
	} prdp_desc_type;

	// One packed payload beat as it waits in the FIFO
	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [QUAL_W-1:0] qual;
		logic              last;
	} prdp_beat_type;
endpackage
`default_nettype wire

// [core/prdp_rx_data_phase.sv]
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module prdp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             rstN,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic                  roomTwo,
	output logic [WIDTH-1:0]      outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr;
	logic [AW-1:0]    rdPtr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	// Honest flags from the fill level
	assign inReady  = count != (AW+1)'(DEPTH);
	assign roomTwo  = count <= (AW+1)'(DEPTH-2); // Covers a registered ready one cycle late
	assign outValid = count != '0;
	assign outData  = mem[rdPtr];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// Storage
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	// Pointers and level
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
module prdp_rx_data_phase import prdp_pkg::*; #(
	parameter int VC_ID         = 0, // One instance per channel, nothing shared
	parameter bit HAS_BYTE_QUAL = 1'b1,
	parameter int DEPTH         = FIFO_DEPTH
) (
	input  wire logic           ref_clk,
	input  wire logic           arst_n,
	input  wire prdp_desc_type  descIn,
	input  wire logic           descInValid,
	output logic                descInReady,
	input  wire logic [DW_W-1:0] dwIn,
	input  wire logic           dwInValid,
	output logic                dwInReady,
	output logic                rxReq,
	output logic [DESC_W-1:0]   rxDesc,
	input  wire logic           rxAck,
	output logic                rxDfr,
	output logic                wordValidStrobe,
	output logic [DATA_W-1:0]   rxData,
	output logic [QUAL_W-1:0]   receiveByteQualifiers,
	input  wire logic           appWaitRequest
);
	logic [1:0]        rstPipe;
	logic              rstN;
	prdp_state_type    state;
	prdp_state_type    next_state;
	logic              take;
	logic              xfer;
	logic              ofsIn;
	logic [LEN_W:0]    beatSum;
	logic [LEN_W-1:0]  beatsLeft;
	logic [LEN_W-1:0]  remDw;
	logic              half;
	logic              dwTake;
	logic              beatPush;
	logic [DW_W-1:0]   laneData [2];
	logic [3:0]        laneQual [2];
	prdp_beat_type     bufBeat;
	prdp_beat_type     pushBeat;
	prdp_beat_type     headBeat;
	logic              headValid;
	logic              roomTwo;
	logic              load;
	logic              outLast;
	logic [BAR_W-1:0]  barIn;

	// Reset release through two flops
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstPipe <= 2'h0;
		end else begin
			rstPipe <= {rstPipe[0], 1'b1};
		end
	end
	assign rstN = rstPipe[1];

	// All checks share the one clock and stay quiet until reset has left the pipe
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstN);

	////////////////////////////////////////////////////////////////////////////
	// Handshakes; a beat moves only when the application is not waiting
	assign take  = descInValid && descInReady;
	assign xfer  = wordValidStrobe && !appWaitRequest;
	assign ofsIn = descIn.desc[ADDR64_BIT] ? descIn.desc[OFS64_BIT]
	                                      : descIn.desc[OFS32_BIT];
	assign beatSum = {1'b0, descIn.lenDw} + (LEN_W+1)'(ofsIn) + (LEN_W+1)'(1);
	assign barIn   = descIn.desc[BAR_LSB +: BAR_W];

	// Sequencer; the acknowledge only closes the descriptor phase
	always_comb begin
		next_state = state;
		unique case (state)
			IDLE: if (take) next_state = REQ;
			REQ:  if (rxAck) next_state = rxDesc[HAS_DATA_BIT] ? DATA : IDLE;
			DATA: if (xfer && outLast) next_state = IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			state       <= IDLE;
			descInReady <= 1'b0;
		end else begin
			state       <= next_state;
			descInReady <= next_state == IDLE && !take;
		end
	end

	// Descriptor phase; a malformed BAR field is cleared rather than shown
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			rxReq  <= 1'b0;
			rxDesc <= '0;
		end else if (take) begin
			rxReq  <= 1'b1;
			rxDesc <= descIn.desc;
			if (!$onehot0(barIn)) begin
				rxDesc[BAR_LSB +: BAR_W] <= '0;
			end
		end else if (rxAck) begin
			rxReq <= 1'b0;
		end
	end

	// Framing rises with the request and falls before the last beat
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			rxDfr     <= 1'b0;
			beatsLeft <= '0;
		end else if (take) begin
			rxDfr     <= descIn.desc[HAS_DATA_BIT];
			beatsLeft <= descIn.desc[HAS_DATA_BIT] ? beatSum[LEN_W:1] : '0;
		end else begin
			if (xfer) begin
				beatsLeft <= beatsLeft - 1'b1;
			end
			if (state == DATA && beatsLeft - LEN_W'(xfer) == LEN_W'(1)) begin
				rxDfr <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Packer: DWORDs fill the beat halves in address order
	assign dwTake   = dwInValid && dwInReady;
	assign beatPush = dwTake && (half || remDw == LEN_W'(1));

	always_comb begin
		pushBeat = bufBeat;
		pushBeat.data[{half, 5'h0} +: DW_W] = dwIn;
		pushBeat.qual[{half, 2'h0} +: 4]    = DW_QUAL;
		pushBeat.last = remDw == LEN_W'(1);
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			remDw     <= '0;
			half      <= 1'b0;
			dwInReady <= 1'b0;
		end else begin
			if (take) begin
				remDw <= descIn.desc[HAS_DATA_BIT] ? descIn.lenDw : '0;
				half  <= ofsIn;
			end else if (dwTake) begin
				remDw <= remDw - 1'b1;
				half  <= !half;
			end
			// Registered ready stays safe because the FIFO keeps two free slots
			dwInReady <= roomTwo && !take && remDw - LEN_W'(dwTake) != '0;
		end
	end

	// One generate lane per beat half
	for (genvar g = 0; g < 2; g++) begin : gLane
		always_ff @(posedge ref_clk or negedge rstN) begin
			if (!rstN) begin
				laneData[g] <= '0;
				laneQual[g] <= 4'h0;
			end else if (beatPush || take) begin
				laneData[g] <= '0;
				laneQual[g] <= 4'h0;
			end else if (dwTake && half == 1'(g)) begin
				laneData[g] <= dwIn;
				laneQual[g] <= DW_QUAL;
			end
		end
	end
	// Separate lane arrays keep one driver per flop; lane 1 is the upper DWORD
	assign bufBeat = {laneData[1], laneData[0], laneQual[1], laneQual[0], 1'b0};

	prdp_fifo #(
		.WIDTH ($bits(prdp_beat_type)),
		.DEPTH (DEPTH)
	) uFifo (
		.ref_clk  (ref_clk),
		.rstN     (rstN),
		.inData   (pushBeat),
		.inValid  (beatPush),
		.inReady  (),
		.roomTwo  (roomTwo),
		.outData  (headBeat),
		.outValid (headValid),
		.outReady (load)
	);

	////////////////////////////////////////////////////////////////////////////
	// Output stage; the last beat waits until framing is already low
	assign load = (!wordValidStrobe || xfer) && headValid && state == DATA
	              && !(headBeat.last && rxDfr);

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			wordValidStrobe <= 1'b0;
			rxData          <= '0;
			outLast         <= 1'b0;
		end else if (load) begin
			wordValidStrobe <= 1'b1;
			rxData          <= headBeat.data;
			outLast         <= headBeat.last;
		end else if (xfer) begin
			wordValidStrobe <= 1'b0;
		end
	end

	// The eight-lane build ties the qualifiers off
	if (HAS_BYTE_QUAL) begin : gQual
		always_ff @(posedge ref_clk or negedge rstN) begin
			if (!rstN) begin
				receiveByteQualifiers <= '0;
			end else if (load) begin
				receiveByteQualifiers <= headBeat.qual;
			end
		end
		chk_qual_valid: assert property (wordValidStrobe |-> receiveByteQualifiers != '0)
			else $error("strobe with no qualified byte");
	end else begin : gNoQual
		always_ff @(posedge ref_clk or negedge rstN) begin
			if (!rstN) begin
				receiveByteQualifiers <= '0;
			end else begin
				receiveByteQualifiers <= '0;
			end
		end
		chk_qual_absent: assert property (receiveByteQualifiers == '0)
			else $error("qualifiers driven in eight-lane build");
	end

	////////////////////////////////////////////////////////////////////////////
	sequence lastShown;
		$rose(wordValidStrobe && outLast);
	endsequence

	chk_bar_onehot: assert property ($onehot0(rxDesc[BAR_LSB +: BAR_W]))
		else $error("more than one BAR decode bit set");
	chk_dfr_with_req: assert property ($rose(rxReq) && rxDesc[HAS_DATA_BIT] |-> rxDfr)
		else $error("framing late for payload packet");
	chk_dfr_before_last: assert property (lastShown |-> !rxDfr && !$past(rxDfr))
		else $error("framing not dropped before last beat");
	chk_strobe_in_data: assert property (wordValidStrobe |-> state == DATA)
		else $error("strobe outside data phase");
	chk_hold_on_wait: assert property (wordValidStrobe && appWaitRequest |=>
		wordValidStrobe && $stable(rxData) && $stable(outLast))
		else $error("beat lost under wait request");
	chk_first_half64: assert property (take && descIn.desc[ADDR64_BIT] |=>
		half == $past(descIn.desc[OFS64_BIT]))
		else $error("wrong first half, 64-bit address");
	chk_first_half32: assert property (take && !descIn.desc[ADDR64_BIT] |=>
		half == $past(descIn.desc[OFS32_BIT]))
		else $error("wrong first half, 32-bit address");
	chk_half_order: assert property (dwTake && !take |=> half != $past(half))
		else $error("DWORD halves out of order");
	chk_no_data: assert property (rxReq && !rxDesc[HAS_DATA_BIT] |-> !rxDfr)
		else $error("framing raised for packet without payload");
	chk_ack_ends_req: assert property (rxAck && state == REQ |=> !rxReq)
		else $error("request held after acknowledge");
endmodule
`default_nettype wire

// [verification/prdp_app_model.sv]
`default_nettype none
module prdp_app_model (
	input  wire logic ref_clk,
	input  wire logic rxReq,
	input  wire logic stallEn,
	output logic      rxAck,
	output logic      appWaitRequest
);
	timeunit 1ns;
	timeprecision 1ps;
	int dly;
	initial begin
		rxAck = 1'b0;
		appWaitRequest = 1'b0;
		dly = 0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// One ack pulse per request after a random delay, blind to data flow
	always @(posedge ref_clk) begin
		if (rxAck) begin
			rxAck <= 1'b0;
		end else if (rxReq === 1'b1) begin
			if (dly == 0) rxAck <= 1'b1;
			else dly <= dly - 1;
		end else begin
			dly <= $urandom_range(3, 0);
		end
	end
	// Wait states at random while stalling, even before any beat is shown
	always @(posedge ref_clk) begin
		appWaitRequest <= stallEn && ($urandom_range(2, 0) != 0);
	end
endmodule
`default_nettype wire

// [verification/prdp_rx_data_phase_tb.sv]
`default_nettype none
module prdp_rx_data_phase_tb import prdp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic                ref_clk, arst_n, descInValid, descInReady, dwInValid, dwInReady;
	logic                rxReq, rxAck, rxDfr, wordValidStrobe, appWaitRequest, stallEn, reqSeen;
	prdp_desc_type       descIn;
	logic [DW_W-1:0]     dwIn;
	logic [DESC_W-1:0]   rxDesc, expDesc;
	logic [DATA_W-1:0]   rxData;
	logic [QUAL_W-1:0]   receiveByteQualifiers;
	logic                strobeNoQual;
	logic [DATA_W-1:0]   dataNoQual;
	logic [QUAL_W-1:0]   qualNoQual;
	logic [72:0]         noQualWant;
	logic [71:0]         got[$], exp[$];
	int                  num_errors, samples_checked, expCount;
	int                  corner[6] = '{1, 1, 2, 0, 5, 40};

	prdp_rx_data_phase u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .descIn(descIn),
		.descInValid(descInValid), .descInReady(descInReady), .dwIn(dwIn),
		.dwInValid(dwInValid), .dwInReady(dwInReady), .rxReq(rxReq), .rxDesc(rxDesc),
		.rxAck(rxAck), .rxDfr(rxDfr), .wordValidStrobe(wordValidStrobe), .rxData(rxData),
		.receiveByteQualifiers(receiveByteQualifiers), .appWaitRequest(appWaitRequest));
	prdp_app_model u_app (.ref_clk(ref_clk), .rxReq(rxReq), .stallEn(stallEn),
		.rxAck(rxAck), .appWaitRequest(appWaitRequest));
	// Eight-lane build on the other virtual channel, fed the same traffic
	prdp_rx_data_phase #(.VC_ID(1), .HAS_BYTE_QUAL(1'b0)) u_dutNoQual (.ref_clk(ref_clk),
		.arst_n(arst_n), .descIn(descIn), .descInValid(descInValid), .descInReady(),
		.dwIn(dwIn), .dwInValid(dwInValid), .dwInReady(), .rxReq(), .rxDesc(), .rxAck(rxAck),
		.rxDfr(), .wordValidStrobe(strobeNoQual), .rxData(dataNoQual),
		.receiveByteQualifiers(qualNoQual), .appWaitRequest(appWaitRequest));

	////////////////////////////////////////////////////////////////////////////////
	// Beats a packet needs once its first DWORD lands in the chosen half
	function automatic int beatCount(input int len, input int pos);
		return (len == 0) ? 0 : (len + pos + 1) / 2;
	endfunction
	// A BAR field with more than one decode bit is shown cleared
	function automatic logic [BAR_W-1:0] expBar(input logic [BAR_W-1:0] bar);
		return ($countones(bar) > 1) ? '0 : bar;
	endfunction
	task automatic check(input logic [DESC_W-1:0] seen, input logic [DESC_W-1:0] want);
		samples_checked++;
		if (seen !== want) begin
			num_errors++;
			$display("BAD %0t: saw %h expected %h", $time, seen, want);
		end
	endtask
	task automatic results();
		$display("checks %0d, errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Bounded wait for a handshake flag sampled at the rising edge
	task automatic waitHigh(ref logic s);
		int n;
		n = 0;
		@(posedge ref_clk);
		while (s !== 1'b1 && n < 2000) begin
			n++;
			@(posedge ref_clk);
		end
		if (n >= 2000) check(1'b0, 1'b1);
	endtask
	// One packet: build descriptor, feed DWORDs, predict beats, compare
	task automatic runTest(input int t);
		logic [DESC_W-1:0] d;
		logic [DW_W-1:0]   dw;
		logic [71:0]       cur;
		int                len, pos;
		len = (t < 6) ? corner[t] : $urandom_range(12, 0);
		d = DESC_W'({$urandom, $urandom, $urandom, $urandom, $urandom});
		d[HAS_DATA_BIT] = (len != 0);
		d[ADDR64_BIT] = (t < 6) ? t[0] : 1'($urandom);
		pos = (t < 6) ? (t[1] ^ t[2]) : $urandom_range(1, 0);
		if (d[ADDR64_BIT]) d[OFS64_BIT] = pos[0];
		else d[OFS32_BIT] = pos[0];
		d[BAR_LSB +: BAR_W] = (t % 3 == 0) ? 8'hc3 : (t % 3 == 1) ? 8'h00 :
			8'h01 << $urandom_range(7, 0);
		expDesc = d;
		expDesc[BAR_LSB +: BAR_W] = expBar(d[BAR_LSB +: BAR_W]);
		expCount = beatCount(len, pos);
		got.delete();
		exp.delete();
		cur = '0;
		stallEn <= t[0] && t >= 5;
		descIn <= '{desc: d, lenDw: len[LEN_W-1:0]};
		descInValid <= 1'b1;
		waitHigh(descInReady);
		descInValid <= 1'b0;
		for (int i = 0; i < len; i++) begin
			dw = $urandom;
			cur[QUAL_W + DW_W * pos +: DW_W] = dw;
			cur[4 * pos +: 4] = DW_QUAL;
			if (pos == 1 || i == len - 1) begin
				exp.push_back(cur);
				cur = '0;
			end
			pos = 1 - pos;
			dwIn <= dw;
			dwInValid <= 1'b1;
			waitHigh(dwInReady);
		end
		dwInValid <= 1'b0;
		waitHigh(descInReady);
		check(DESC_W'(got.size()), DESC_W'(exp.size()));
		foreach (exp[i]) if (i < got.size()) check(got[i], exp[i]);
		$display("test %0d done, %0d beats", t, got.size());
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Watch descriptor start and every beat that actually moves
	always @(posedge ref_clk) begin
		reqSeen <= rxReq;
		if (rxReq === 1'b1 && reqSeen !== 1'b1) begin
			check(rxDesc, expDesc);
			check(rxDfr, expDesc[HAS_DATA_BIT]);
		end
		if (wordValidStrobe === 1'b1) check(got.size() < expCount, 1'b1);
		if (wordValidStrobe === 1'b1 && appWaitRequest === 1'b0) begin
			got.push_back({rxData, receiveByteQualifiers});
			check(rxDfr, got.size() < expCount);
			if (got.size() <= exp.size()) begin
				noQualWant = {1'b1, exp[got.size() - 1][DATA_W+QUAL_W-1:QUAL_W], QUAL_W'(0)};
				check({strobeNoQual, dataNoQual, qualNoQual}, noQualWant);
			end
		end
	end
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// Watchdog: 40 packets need a few thousand cycles at most
	initial begin
		#(8 * 60000);
		num_errors++;
		results();
	end
	initial begin
		arst_n = 1'b0;
		descInValid = 1'b0;
		dwInValid = 1'b0;
		descIn = '0;
		dwIn = '0;
		stallEn = 1'b0;
		num_errors = 0;
		samples_checked = 0;
		expCount = 0;
		expDesc = '0;
		void'($urandom(32'ha0819b22));
		repeat (6) @(posedge ref_clk);
		arst_n <= 1'b1;
		for (int t = 0; t < 40; t++) runTest(t);
		results();
	end
endmodule
`default_nettype wire
